// ==== dcf_regs.sv ====
// Debug channel FIFO register block: core-side FIFOs, registers, probe crossing
// Overview of operation
// - Configuration bits 31:20 read as zero.
// - Transmit threshold resets 0: off, empty, not full, almost empty.
// - Receive threshold resets 0; code 2 not empty, code 3 almost full.
// - Configuration shows fixed transmit depth 15:8, receive depth 7:0.
// - Status bits 31:16 always read zero.
// - Status bits 15:8 read as zero.
// - Status 7:4 show oldest receive entry tag, valid when not empty.
// - Status bit 3 is receive empty, reset one.
// - Status bit 2 is receive full, reset zero.
// - Status bit 1 is transmit empty, reset one.
// - Status bit 0 is transmit full, reset zero.
// - Reading receive data returns oldest word and pops it.
// - Sixteen transmit registers at 0x20 plus 8n; n is channel tag.
// - Transmit write pushes word with decoded tag into transmit FIFO.
// - Almost empty means every core-side transmit entry is empty.
// - Probe exchanges data through a 38-bit two-way scan register.
`timescale 1ns/1ps
module dcf_regs #(
   parameter int unsigned TX_DEPTH = 4,
   parameter int unsigned RX_DEPTH = 4
) (
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        reg_sel,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   output logic             irq_q,
   input  wire logic        probe_scan_clock,
   input  wire logic        probe_rst_b,
   input  wire logic        scan_load,
   input  dcf_pkg::dcf_scan_t scan_in,
   output dcf_pkg::dcf_scan_t scan_out
);

   localparam int unsigned TAW = $clog2(TX_DEPTH);
   localparam int unsigned RAW = $clog2(RX_DEPTH);
   // Crossing slot on the probe side counts as one extra entry
   localparam logic [7:0] TX_DEP_V = 8'(TX_DEPTH + 1);
   localparam logic [7:0] RX_DEP_V = 8'(RX_DEPTH + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Register access decode
   logic       tx_hit;
   logic       wr_tx;
   logic       rd_rx;
   logic [3:0] tx_tag;
   localparam int unsigned TX_STRIDE_M = dcf_pkg::TX_STRIDE_LSB - 1;
   assign tx_hit = (reg_addr >= dcf_pkg::OFF_TXBASE) && (reg_addr <= dcf_pkg::OFF_TXLAST)
                   && (reg_addr[TX_STRIDE_M:0] == '0);
   assign tx_tag = 4'((reg_addr - dcf_pkg::OFF_TXBASE) >> dcf_pkg::TX_STRIDE_LSB);
   assign wr_tx  = reg_sel && reg_wr && tx_hit;
   assign rd_rx  = reg_sel && !reg_wr && (reg_addr == dcf_pkg::OFF_RXPOP);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration thresholds
   logic [1:0] tx_lvl_q;
   logic [1:0] rx_lvl_q;
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_lvl_q <= dcf_pkg::LVL_OFF;
         rx_lvl_q <= dcf_pkg::LVL_OFF;
      end
      else if (reg_sel && reg_wr && reg_addr == dcf_pkg::OFF_CONFIG)
      begin
         tx_lvl_q <= reg_wdata[dcf_pkg::CFG_TXLVL_LSB +: 2];
         rx_lvl_q <= reg_wdata[dcf_pkg::CFG_RXLVL_LSB +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit FIFO, core side
   logic [TAW:0]        tx_wp_q, tx_rp_q;
   logic                tx_full, tx_empty, tx_pop;
   dcf_pkg::dcf_entry_t tx_wdata, tx_head;
   assign tx_wdata = '{tag: tx_tag, word: reg_wdata};
   assign tx_empty = (tx_wp_q == tx_rp_q);
   assign tx_full  = (tx_wp_q[TAW-1:0] == tx_rp_q[TAW-1:0]) && (tx_wp_q[TAW] != tx_rp_q[TAW]);

   // Push when not full; a write to a full FIFO is dropped
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_wp_q <= '0;
      end
      else if (wr_tx && !tx_full)
      begin
         tx_wp_q <= tx_wp_q + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_rp_q <= '0;
      end
      else if (tx_pop)
      begin
         tx_rp_q <= tx_rp_q + 1'b1;
      end
   end

   // Read address looks ahead so the registered head follows a pop
   dcf_mem #(.DEPTH(TX_DEPTH), .AW(TAW)) u_tx_mem (
      .clock (clock),
      .we    (wr_tx && !tx_full),
      .waddr (tx_wp_q[TAW-1:0]),
      .wdata (tx_wdata),
      .raddr (tx_pop ? TAW'(tx_rp_q[TAW-1:0] + 1'b1) : tx_rp_q[TAW-1:0]),
      .rdata (tx_head)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Receive FIFO, core side
   logic [RAW:0]        rx_wp_q, rx_rp_q;
   logic                rx_full, rx_empty, rx_push, rx_pop;
   dcf_pkg::dcf_entry_t rx_head, rx_slot, rx_front, rx_byp_word_q;
   logic [RAW-1:0]      rx_raddr;
   logic                rx_byp_q;
   assign rx_empty = (rx_wp_q == rx_rp_q);
   assign rx_full  = (rx_wp_q[RAW-1:0] == rx_rp_q[RAW-1:0]) && (rx_wp_q[RAW] != rx_rp_q[RAW]);
   assign rx_pop   = rd_rx && !rx_empty;
   assign rx_raddr = rx_pop ? RAW'(rx_rp_q[RAW-1:0] + 1'b1) : rx_rp_q[RAW-1:0];

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_wp_q <= '0;
      end
      else if (rx_push)
      begin
         rx_wp_q <= rx_wp_q + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_rp_q <= '0;
      end
      else if (rx_pop)
      begin
         rx_rp_q <= rx_rp_q + 1'b1;
      end
   end

   dcf_mem #(.DEPTH(RX_DEPTH), .AW(RAW)) u_rx_mem (
      .clock (clock),
      .we    (rx_push),
      .waddr (rx_wp_q[RAW-1:0]),
      .wdata (rx_slot),
      .raddr (rx_raddr),
      .rdata (rx_head)
   );

   // A word written into the slot being read misses the registered read,
   // so it is kept aside for one cycle and shown as the head instead
   assign rx_front = rx_byp_q ? rx_byp_word_q : rx_head;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_byp_q      <= 1'b0;
         rx_byp_word_q <= '0;
      end
      else
      begin
         rx_byp_q <= rx_push && (rx_wp_q[RAW-1:0] == rx_raddr);
         if (rx_push)
         begin
            rx_byp_word_q <= rx_slot;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit crossing: core hands head entry to probe slot by toggle handshake
   logic    tx_req_q, tx_ack_s1, tx_ack_s2;
   logic    tx_ack_p;
   dcf_pkg::dcf_xs_t tx_xs_q;
   dcf_pkg::dcf_entry_t tx_hold_q;
   // Pop only when head read data has settled (one cycle after pointer move)
   logic    tx_head_ok_q;
   assign tx_pop = (tx_xs_q == dcf_pkg::XS_IDLE) && !tx_empty && tx_head_ok_q;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_head_ok_q <= 1'b0;
      end
      else
      begin
         tx_head_ok_q <= !tx_pop && !(wr_tx && tx_empty);
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_ack_s1 <= 1'b0;
         tx_ack_s2 <= 1'b0;
      end
      else
      begin
         tx_ack_s1 <= tx_ack_p;
         tx_ack_s2 <= tx_ack_s1;
      end
   end

   // One entry in flight; slot busy until probe side acknowledges
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tx_xs_q   <= dcf_pkg::XS_IDLE;
         tx_req_q  <= 1'b0;
         tx_hold_q <= '0;
      end
      else
      begin
         case (tx_xs_q)
            dcf_pkg::XS_IDLE:
            begin
               if (tx_pop)
               begin
                  tx_hold_q <= tx_head;
                  tx_req_q  <= !tx_req_q;
                  tx_xs_q   <= dcf_pkg::XS_BUSY;
               end
            end
            dcf_pkg::XS_BUSY:
            begin
               if (tx_ack_s2 == tx_req_q)
               begin
                  tx_xs_q <= dcf_pkg::XS_IDLE;
               end
            end
            default:
            begin
               tx_xs_q <= dcf_pkg::XS_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive crossing: probe toggles a request, core pushes when room
   logic rx_req_p, rx_req_s1, rx_req_s2, rx_ack_q;
   dcf_pkg::dcf_entry_t rx_pword_q;
   assign rx_push = (rx_req_s2 != rx_ack_q) && !rx_full;

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_req_s1 <= 1'b0;
         rx_req_s2 <= 1'b0;
         rx_ack_q  <= 1'b0;
      end
      else
      begin
         rx_req_s1 <= rx_req_p;
         rx_req_s2 <= rx_req_s1;
         if (rx_req_s2 != rx_ack_q && !rx_full)
         begin
            rx_ack_q <= rx_req_s2;
         end
      end
   end
   // Data word is stable while a request is outstanding
   assign rx_slot = rx_pword_q;

   ////////////////////////////////////////////////////////////////////////////
   // Probe domain: 38-bit scan register exchange
   logic tx_req_ps1, tx_req_ps2, tx_ack_q;
   logic rx_ack_ps1, rx_ack_ps2, rx_req_q;
   dcf_pkg::dcf_scan_t scan_q;
   assign tx_ack_p = tx_ack_q;
   assign rx_req_p = rx_req_q;

   always_ff @(posedge probe_scan_clock or negedge probe_rst_b)
   begin
      if (!probe_rst_b)
      begin
         tx_req_ps1 <= 1'b0;
         tx_req_ps2 <= 1'b0;
         rx_ack_ps1 <= 1'b0;
         rx_ack_ps2 <= 1'b0;
      end
      else
      begin
         tx_req_ps1 <= tx_req_q;
         tx_req_ps2 <= tx_req_ps1;
         rx_ack_ps1 <= rx_ack_q;
         rx_ack_ps2 <= rx_ack_ps1;
      end
   end

   // On each update: accept a valid inbound word if slot free, retire outbound if probe took it
   always_ff @(posedge probe_scan_clock or negedge probe_rst_b)
   begin
      if (!probe_rst_b)
      begin
         tx_ack_q   <= 1'b0;
         rx_req_q   <= 1'b0;
         rx_pword_q <= '0;
         scan_q     <= '0;
      end
      else if (scan_load)
      begin
         if (scan_in.valid && (rx_ack_ps2 == rx_req_q))
         begin
            rx_pword_q <= scan_in.ent;
            rx_req_q   <= !rx_req_q;
         end
         if (scan_q.valid && scan_in.flag)
         begin
            tx_ack_q <= tx_req_ps2;
         end
         scan_q.valid <= (tx_req_ps2 != tx_ack_q) && !(scan_q.valid && scan_in.flag);
         scan_q.ent   <= tx_hold_q;
         scan_q.flag  <= (rx_ack_ps2 != rx_req_q) || scan_in.valid;
      end
   end
   assign scan_out = scan_q;

   ////////////////////////////////////////////////////////////////////////////
   // Read data and interrupt request
   logic [31:0] rdata_d;
   logic        irq_d;
   always_comb
   begin
      rdata_d = '0;
      if (reg_addr == dcf_pkg::OFF_CONFIG)
      begin
         rdata_d[dcf_pkg::CFG_TXLVL_LSB +: 2] = tx_lvl_q;
         rdata_d[dcf_pkg::CFG_RXLVL_LSB +: 2] = rx_lvl_q;
         rdata_d[dcf_pkg::CFG_TXDEP_LSB +: 8] = TX_DEP_V;
         rdata_d[dcf_pkg::CFG_RXDEP_LSB +: 8] = RX_DEP_V;
      end
      else if (reg_addr == dcf_pkg::OFF_STATUS)
      begin
         rdata_d[dcf_pkg::ST_TAG_LSB +: 4] = rx_empty ? 4'h0 : rx_front.tag;
         rdata_d[dcf_pkg::ST_RXE_BIT]      = rx_empty;
         rdata_d[dcf_pkg::ST_RXF_BIT]      = rx_full;
         rdata_d[dcf_pkg::ST_TXE_BIT]      = tx_empty && tx_xs_q == dcf_pkg::XS_IDLE;
         rdata_d[dcf_pkg::ST_TXF_BIT]      = tx_full;
      end
      else if (reg_addr == dcf_pkg::OFF_RXPOP)
      begin
         rdata_d = rx_front.word;
      end
      irq_d = 1'b0;
      case (tx_lvl_q)
         dcf_pkg::LVL_ONE: irq_d = tx_empty && tx_xs_q == dcf_pkg::XS_IDLE;
         dcf_pkg::LVL_TWO: irq_d = !tx_full;
         dcf_pkg::LVL_THR: irq_d = tx_empty;
         default:          irq_d = 1'b0;
      endcase
      case (rx_lvl_q)
         dcf_pkg::LVL_ONE: irq_d = irq_d || rx_full;
         dcf_pkg::LVL_TWO: irq_d = irq_d || !rx_empty;
         dcf_pkg::LVL_THR: irq_d = irq_d || rx_full ||
                                   (RAW'(rx_wp_q - rx_rp_q) == RAW'(RX_DEPTH - 1) && !rx_empty);
         default:          irq_d = irq_d;
      endcase
   end

   // Read data and request registered; reads appear one cycle after select
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reg_rdata <= '0;
         irq_q     <= 1'b0;
      end
      else
      begin
         reg_rdata <= (reg_sel && !reg_wr) ? rdata_d : '0;
         irq_q     <= irq_d;
      end
   end

endmodule

// ==== dcf_pkg.sv ====
// Package for the debug channel FIFO register block: offsets, fields, types
package dcf_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_CONFIG  = 8'h08;
   localparam logic [7:0] OFF_STATUS  = 8'h10;
   localparam logic [7:0] OFF_RXPOP   = 8'h18;
   localparam logic [7:0] OFF_TXBASE  = 8'h20;
   localparam logic [7:0] OFF_TXLAST  = 8'h98;
   localparam int unsigned TX_STRIDE_LSB = 3;

   // Configuration fields
   localparam int unsigned CFG_TXLVL_LSB = 18;
   localparam int unsigned CFG_RXLVL_LSB = 16;
   localparam int unsigned CFG_TXDEP_LSB = 8;
   localparam int unsigned CFG_RXDEP_LSB = 0;

   // Status fields
   localparam int unsigned ST_TAG_LSB   = 4;
   localparam int unsigned ST_RXE_BIT   = 3;
   localparam int unsigned ST_RXF_BIT   = 2;
   localparam int unsigned ST_TXE_BIT   = 1;
   localparam int unsigned ST_TXF_BIT   = 0;

   // Threshold codes
   localparam logic [1:0] LVL_OFF  = 2'h0;
   localparam logic [1:0] LVL_ONE  = 2'h1;
   localparam logic [1:0] LVL_TWO  = 2'h2;
   localparam logic [1:0] LVL_THR  = 2'h3;

   // Probe scan register positions (38 bits)
   localparam int unsigned SCAN_W     = 38;
   localparam int unsigned SCAN_FLAG  = 37;
   localparam int unsigned SCAN_VALID = 36;

   // A tagged channel word
   typedef struct packed {
      logic [3:0]  tag;
      logic [31:0] word;
   } dcf_entry_t;

   // Scan register layout
   typedef struct packed {
      logic       flag;
      logic       valid;
      dcf_entry_t ent;
   } dcf_scan_t;

   // Handshake states of a crossing slot
   typedef enum logic [1:0] {
      XS_IDLE = 2'b01,
      XS_BUSY = 2'b10
   } dcf_xs_t;

endpackage

// ==== dcf_mem.sv ====
// Small FIFO storage array with registered read data
`timescale 1ns/1ps
module dcf_mem #(
   parameter int unsigned DEPTH = 4,
   parameter int unsigned AW    = 2
) (
   input  wire logic               clock,
   input  wire logic               we,
   input  wire logic [AW-1:0]      waddr,
   input  dcf_pkg::dcf_entry_t     wdata,
   input  wire logic [AW-1:0]      raddr,
   output dcf_pkg::dcf_entry_t     rdata
);

   dcf_pkg::dcf_entry_t mem_q [DEPTH];

   // Write port, no reset on storage to keep it RAM-like
   always_ff @(posedge clock)
   begin
      if (we)
      begin
         mem_q[waddr] <= wdata;
      end
   end

   // Registered read so the head word is a flop output
   always_ff @(posedge clock)
   begin
      rdata <= mem_q[raddr];
   end

endmodule

// ==== dcf_asserts.sv ====
// Checker for the debug channel register block, bound to its top module
`timescale 1ns/1ps
module dcf_chk #(
   parameter int unsigned TX_DEPTH = 4,
   parameter int unsigned RX_DEPTH = 4
) (
   input wire logic         clock,
   input wire logic         rst_b,
   input wire logic         reg_sel,
   input wire logic         reg_wr,
   input wire logic [7:0]   reg_addr,
   input wire logic [31:0]  reg_wdata,
   input wire logic [31:0]  reg_rdata,
   input wire logic         irq_q,
   input wire logic         probe_scan_clock,
   input wire logic         probe_rst_b,
   input wire logic         scan_load,
   input dcf_pkg::dcf_scan_t scan_in,
   input dcf_pkg::dcf_scan_t scan_out
);
   logic       rd;
   logic       cf;
   logic       st;
   logic [2:0] off_cnt_q;

   // Read strobes decoded per register
   assign rd = reg_sel && !reg_wr;
   assign cf = rd && reg_addr == dcf_pkg::OFF_CONFIG;
   assign st = rd && reg_addr == dcf_pkg::OFF_STATUS;

   // Cycles since both levels went to zero; 7 marks levels enabled
   always_ff @(posedge clock or negedge rst_b)
      if (!rst_b)
         off_cnt_q <= 3'h3;
      else if (reg_sel && reg_wr && reg_addr == dcf_pkg::OFF_CONFIG)
         off_cnt_q <= (reg_wdata[19:16] == 4'h0) ? 3'h0 : 3'h7;
      else if (off_cnt_q < 3'h3)
         off_cnt_q <= off_cnt_q + 3'h1;

   ////////////////////////////////////////////////////////////////////////////////
   AST_RD_IDLE: assert property (@(posedge clock) disable iff (!rst_b)
      !rd |=> reg_rdata == 32'h0000_0000) else $error("read data not zero when idle");
   AST_CFG_RSVD: assert property (@(posedge clock) disable iff (!rst_b)
      cf |=> reg_rdata[31:20] == 12'h000) else $error("config high bits not zero");
   AST_CFG_DEPTH: assert property (@(posedge clock) disable iff (!rst_b)
      cf |=> reg_rdata[15:0] == {8'(TX_DEPTH + 1), 8'(RX_DEPTH + 1)}) else $error("depth fields wrong");
   AST_ST_ZERO: assert property (@(posedge clock) disable iff (!rst_b)
      st |=> reg_rdata[31:8] == 24'h00_0000) else $error("status upper bits not zero");
   AST_ST_FLAGS: assert property (@(posedge clock) disable iff (!rst_b)
      st |=> !(reg_rdata[3] && reg_rdata[2]) && !(reg_rdata[1] && reg_rdata[0])) else $error("empty and full");
   AST_UNMAPPED: assert property (@(posedge clock) disable iff (!rst_b)
      rd && (reg_addr < dcf_pkg::OFF_CONFIG || reg_addr > dcf_pkg::OFF_TXLAST) |=> reg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_IRQ_OFF: assert property (@(posedge clock) disable iff (!rst_b)
      off_cnt_q == 3'h3 |-> !irq_q) else $error("interrupt with levels off");
   AST_SCAN_HOLD: assert property (@(posedge probe_scan_clock) disable iff (!probe_rst_b)
      !scan_load |=> $stable(scan_out)) else $error("scan output moved without load");
endmodule

bind dcf_regs dcf_chk #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH)) u_chk (
   .clock(clock), .rst_b(rst_b), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_q(irq_q), .probe_scan_clock(probe_scan_clock),
   .probe_rst_b(probe_rst_b), .scan_load(scan_load), .scan_in(scan_in), .scan_out(scan_out));

// ==== dcf_probe.sv ====
// Behavioural debug probe driving the scan register on the link clock
`timescale 1ns/1ps
module dcf_probe (
   output logic               probe_scan_clock,
   output logic               scan_load,
   output dcf_pkg::dcf_scan_t scan_in,
   input  dcf_pkg::dcf_scan_t scan_out,
   input  wire logic          run,
   input  wire logic          slow
);
   dcf_pkg::dcf_entry_t to_core[$];
   dcf_pkg::dcf_entry_t from_core[$];
   logic                accept = 1'b0;
   logic                full = 1'b0;

   // One load per frame; clock stands still while not running
   initial
   begin
      probe_scan_clock = 1'b0;
      scan_load = 1'b0;
      scan_in = '0;
      forever
      begin
         wait (run);
         scan_load = 1'b1;
         scan_in.flag = accept;
         scan_in.valid = to_core.size() > 0 && !full;
         scan_in.ent = scan_in.valid ? to_core[0] : ~scan_in.ent;
         #7.5 probe_scan_clock = 1'b1;
         #1;
         if (scan_in.valid)
            void'(to_core.pop_front());
         // Accept whatever is offered, retired on the next load
         accept = scan_out.valid;
         if (accept)
            from_core.push_back(scan_out.ent);
         full = scan_out.flag;
         #6.5 probe_scan_clock = 1'b0;
         scan_load = 1'b0;
         scan_in = ~scan_in; // Released lines carry no stale value
         repeat (slow ? 3 : 1)
         begin
            #7.5 probe_scan_clock = 1'b1;
            #7.5 probe_scan_clock = 1'b0;
         end
      end
   end
endmodule

// ==== debug_channel_fifo_regs_bench.sv ====
// Self-checking bench for the debug channel register block
`timescale 1ns/1ps
module debug_channel_fifo_regs_bench;
   localparam int TXD = 4;
   localparam int RXD = 4;
   logic               clock = 1'b0;
   logic               rst_b = 1'b0;
   logic               probe_rst_b = 1'b0;
   logic               reg_sel = 1'b0;
   logic               reg_wr = 1'b0;
   logic [7:0]         reg_addr = 8'h00;
   logic [31:0]        reg_wdata = 32'h0000_0000;
   logic [31:0]        reg_rdata;
   logic               irq_q;
   logic               probe_scan_clock;
   logic               scan_load;
   logic               run = 1'b1;
   logic               slow = 1'b0;
   logic [31:0]        seed = 32'h0001_82A0;
   logic [31:0]        q;
   logic [31:0]        w [16];
   dcf_pkg::dcf_entry_t e;
   dcf_pkg::dcf_entry_t exp_q[$];
   dcf_pkg::dcf_scan_t scan_in;
   dcf_pkg::dcf_scan_t scan_out;
   int                 error_cnt = 0;
   int                 checked = 0;

   // Core clock at 200 MHz
   always #2.5 clock = ~clock;

   dcf_regs #(.TX_DEPTH(TXD), .RX_DEPTH(RXD)) dut (
      .clock(clock), .rst_b(rst_b), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_q(irq_q), .probe_scan_clock(probe_scan_clock),
      .probe_rst_b(probe_rst_b), .scan_load(scan_load), .scan_in(scan_in), .scan_out(scan_out));
   dcf_probe probe (.probe_scan_clock(probe_scan_clock), .scan_load(scan_load), .scan_in(scan_in),
      .scan_out(scan_out), .run(run), .slow(slow));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] cfg_exp(logic [1:0] tl, logic [1:0] rl);
      return {12'h000, tl, rl, 8'(TXD + 1), 8'(RXD + 1)};
   endfunction
   // Transmit side is empty whenever this is used
   function automatic logic irq_exp(logic [3:0] c, logic receive_full_flag, logic receive_empty_flag);
      return (c[3:2] != 2'h0) || (c[1:0] == 2'h2 ? !receive_empty_flag : (c[1:0] != 2'h0 && receive_full_flag));
   endfunction

   task automatic check(string nm, logic [31:0] ex, logic [31:0] got);
      checked++;
      if (got !== ex)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h got %h", nm, ex, got);
      end
   endtask
   // One access; read data sampled one cycle after the strobe
   task automatic acc(logic wr, logic [7:0] a, logic [31:0] d);
      @(posedge clock);
      reg_sel <= 1'b1;
      reg_wr <= wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_sel <= 1'b0;
      #1 q = reg_rdata;
   endtask
   task automatic wait_bit(int b, logic v);
      for (int i = 0; i < 400; i++)
      begin
         acc(1'b0, dcf_pkg::OFF_STATUS, 32'h0000_0000);
         if (q[b] === v)
            break;
      end
      check("status wait", 32'(v), 32'(q[b]));
   endtask
   task automatic irq_tab(logic receive_full_flag, logic receive_empty_flag);
      logic x;
      for (int c = 0; c < 16; c++)
      begin
         acc(1'b1, dcf_pkg::OFF_CONFIG, 32'(c) << 16);
         acc(1'b0, dcf_pkg::OFF_CONFIG, 32'h0000_0000);
         check("config", cfg_exp(2'(c >> 2), 2'(c)), q);
         x = irq_exp(4'(c), receive_full_flag, receive_empty_flag);
         for (int i = 0; i < 8 && irq_q !== x; i++)
            @(posedge clock);
         check("irq", 32'(x), 32'(irq_q));
      end
      acc(1'b1, dcf_pkg::OFF_CONFIG, 32'h0000_0000);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      probe_rst_b <= 1'b1;
      acc(1'b0, dcf_pkg::OFF_STATUS, 32'h0000_0000);
      check("status", 32'h0000_000A, q);
      acc(1'b0, dcf_pkg::OFF_CONFIG, 32'h0000_0000);
      check("config", cfg_exp(2'h0, 2'h0), q);
      acc(1'b1, dcf_pkg::OFF_CONFIG, 32'hFFFF_FFFF);
      acc(1'b0, dcf_pkg::OFF_CONFIG, 32'h0000_0000);
      check("config", cfg_exp(2'h3, 2'h3), q);
      acc(1'b1, 8'h00, rnd());
      acc(1'b0, 8'h00, 32'h0000_0000);
      check("unmapped", 32'h0000_0000, q);
      irq_tab(1'b0, 1'b1);
      $display("register and interrupt test done");
      // Stall the probe so the transmit FIFO fills, then let it drain
      run <= 1'b0;
      for (int n = 0; n < 16; n++)
      begin
         acc(1'b0, dcf_pkg::OFF_STATUS, 32'h0000_0000);
         if (q[0] === 1'b1 && run === 1'b0)
         begin
            check("fill count", 1, 32'(n >= TXD && n <= TXD + 1));
            check("tx empty", 0, q[1]);
            run <= 1'b1;
         end
         wait_bit(0, 1'b0);
         w[n] = rnd();
         acc(1'b1, 8'h20 + 8'(n) * 8'h08, w[n]);
      end
      check("full seen", 1, run);
      for (int i = 0; i < 4000 && probe.from_core.size() < 16; i++)
         @(posedge clock);
      check("tx count", 16, probe.from_core.size());
      for (int n = 0; n < 16; n++)
      begin
         e = probe.from_core.pop_front();
         check("tx tag", n, e.tag);
         check("tx word", w[n], e.word);
      end
      wait_bit(1, 1'b1);
      check("tx empty", 1, q[1]);
      $display("transmit test done");
      // Slow probe overfills the receive side; one word waits refused
      slow <= 1'b1;
      for (int n = 0; n < RXD + 2; n++)
      begin
         e = {4'(rnd()), rnd()};
         exp_q.push_back(e);
         probe.to_core.push_back(e);
      end
      wait_bit(2, 1'b1);
      check("rx full", 1, q[2]);
      check("rx empty", 0, q[3]);
      irq_tab(1'b1, 1'b0);
      for (int n = 0; n < RXD + 2; n++)
      begin
         wait_bit(3, 1'b0);
         e = exp_q.pop_front();
         check("rx tag", e.tag, q[7:4]);
         acc(1'b0, dcf_pkg::OFF_RXPOP, 32'h0000_0000);
         check("rx word", e.word, q);
      end
      wait_bit(3, 1'b1);
      check("rx empty", 1, q[3]);
      $display("receive test done");
      summarize();
   end

   // Watchdog against a hung handshake
   initial
   begin
      #300000;
      error_cnt++;
      $display("[FAIL] watchdog expected finish got timeout");
      summarize();
   end
endmodule
